// file: hdl/scpi_status_event_reporting.sv
// Status and event reporting core with a test parameter store.
// Assumes a command decoder on the same clock presents one decoded
// command or query per cycle; condition inputs come from pins.
//
// Contract
// [RULE1] Live bits track their conditions continuously, nothing latched.
// [RULE2] Live bit is 1 while its condition holds, 0 otherwise.
// [RULE3] Latched bit sets on a false-to-true change of its live bit.
// [RULE4] Once set, a latched bit ignores later live changes.
// [RULE5] Latched bit stays set until its event register is read.
// [RULE6] Clear-status command clears every latched register.
// [RULE7] Each status bit has an enable bit gating its report.
// [RULE8] Service request is raised as the last reporting stage.
// [RULE9] Warning and operation groups each hold three 16-bit registers. The operation group here has no live register, only latched and mask.
// [RULE10] Warning live query returns the register and does not clear it.
// [RULE11] Warning latched query returns and clears that register.
// [RULE12] Insulation voltage accepts only 50, 100, 500, 1000; query reads it.
// [RULE13] Each test parameter is written by set and read by query.
// [RULE14] Status byte bit 3 summarises enabled warning events.
// [RULE15] Summary is OR over bits of status AND enable.
// [RULE16] Operation enable exists but no operation bit ever asserts.
// [RULE17] Unused bit positions always read zero. The service request enable keeps bits 0-2, 4 and 5 as written.
`timescale 1ns/1ps
`include "scpi_status_map.svh"

module scpi_status_event_reporting (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_reset_n,
  input  wire logic [`GROUP_W-1:0]         i_warn_cond,
  input  wire scpi_status_pkg::cmd_t       i_cmd,
  output logic                             o_resp_valid,
  output logic                             o_resp_err,
  output logic [`PARAM_W-1:0]              o_resp_data,
  output logic [`STB_W-1:0]                o_status_byte,
  output logic                             o_srq
);

  // Warning group keeps live, latched and mask words of full width; operation group keeps only latched and mask
  scpi_status_pkg::state_t state; // RULE9
  scpi_status_pkg::state_t next_state;

  logic [`GROUP_W-1:0] warn_rise;
  logic [`GROUP_W-1:0] warn_clr;
  logic [`GROUP_W-1:0] op_clr;
  logic                warn_sum;
  logic                op_sum;
  logic [`STB_W-1:0]   next_stb;
  logic                ins_ok;

  // Rising edges of the synchronised live bits, per bit
  genvar gi;
  generate
    for (gi = 0; gi < `GROUP_W; gi++) begin : g_edge
      assign warn_rise[gi] = state.warn_live[gi] & ~state.warn_prev[gi]; // RULE3
    end
  endgenerate

  // Only the four documented insulation voltages are stored
  assign ins_ok = (i_cmd.data == `INS_V_50) ||
                  (i_cmd.data == `INS_V_100) ||
                  (i_cmd.data == `INS_V_500) ||
                  (i_cmd.data == `INS_V_1000); // RULE12

  // Next state of the whole block
  always_comb begin
    next_state = state;
    warn_clr   = '0;
    op_clr     = '0;
    next_state.resp = '0;

    // One sync flop then the live register; the sync stage feeds only live
    next_state.warn_sync = i_warn_cond;
    next_state.warn_live = state.warn_sync & `WARN_USED_MASK; // RULE1 RULE2 RULE17
    next_state.warn_prev = state.warn_live;

    if (i_cmd.valid) begin
      next_state.resp.valid = 1'b1;
      case (i_cmd.code)
        scpi_status_pkg::CMD_CLEAR_STATUS: begin
          warn_clr = '1; // RULE6
          op_clr   = '1;
        end
        scpi_status_pkg::CMD_WARN_LIVE_Q: begin
          next_state.resp.data = state.warn_live; // RULE10
        end
        scpi_status_pkg::CMD_WARN_LATCHED_Q: begin
          next_state.resp.data = state.warn_latched;
          warn_clr = '1; // RULE11 RULE5
        end
        scpi_status_pkg::CMD_WARN_MASK_SET: begin
          next_state.warn_mask = i_cmd.data & `WARN_USED_MASK; // RULE17
        end
        scpi_status_pkg::CMD_WARN_MASK_Q: begin
          next_state.resp.data = state.warn_mask;
        end
        scpi_status_pkg::CMD_OP_LIVE_Q: begin
          next_state.resp.data = `OP_USED_MASK; // RULE16
        end
        scpi_status_pkg::CMD_OP_LATCHED_Q: begin
          next_state.resp.data = state.op_latched;
          op_clr = '1; // RULE5
        end
        scpi_status_pkg::CMD_OP_MASK_SET: begin
          next_state.op_mask = i_cmd.data & `OP_USED_MASK; // RULE16 RULE17
        end
        scpi_status_pkg::CMD_OP_MASK_Q: begin
          next_state.resp.data = state.op_mask;
        end
        scpi_status_pkg::CMD_SRE_SET: begin
          // RQS position cannot enable itself
          next_state.sre_mask = i_cmd.data[`STB_W-1:0] &
                                ~(8'h01 << `STB_RQS_BIT);
        end
        scpi_status_pkg::CMD_SRE_Q: begin
          next_state.resp.data = {8'h00, state.sre_mask};
        end
        scpi_status_pkg::CMD_STB_Q: begin
          next_state.resp.data = {8'h00, state.stb};
        end
        scpi_status_pkg::CMD_PARAM_SET: begin
          if (i_cmd.index == `P_INS_VOLT && !ins_ok) begin
            next_state.resp.err = 1'b1; // RULE12
          end else begin
            next_state.params[i_cmd.index] = i_cmd.data; // RULE13
          end
        end
        scpi_status_pkg::CMD_PARAM_Q: begin
          next_state.resp.data = state.params[i_cmd.index]; // RULE13
        end
        default: begin
          next_state.resp.err = 1'b1;
        end
      endcase
    end

    // A rise in the same cycle as a read wins over the clear
    next_state.warn_latched = ((state.warn_latched & ~warn_clr) | warn_rise)
                              & `WARN_USED_MASK; // RULE3 RULE4 RULE5
    next_state.op_latched   = (state.op_latched & ~op_clr) & `OP_USED_MASK; // RULE16

    next_state.stb = next_stb;
    next_state.srq = |(next_stb & state.sre_mask); // RULE8
  end

  // Summary bits and status byte from the current latched registers
  assign warn_sum = |(state.warn_latched & state.warn_mask); // RULE7 RULE15
  assign op_sum   = |(state.op_latched & state.op_mask); // RULE15

  always_comb begin
    next_stb = 8'h00;
    next_stb[`STB_WARN_BIT] = warn_sum; // RULE14
    next_stb[`STB_OP_BIT]   = op_sum;
    next_stb[`STB_RQS_BIT]  = |(next_stb & state.sre_mask); // RULE8
  end

  // Single state register; control state defined at reset
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state              <= '0;
      state.warn_mask    <= `MASK_RESET;
      state.op_mask      <= `MASK_RESET;
      state.sre_mask     <= `SRE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign o_resp_valid  = state.resp.valid;
  assign o_resp_err    = state.resp.err;
  assign o_resp_data   = state.resp.data;
  assign o_status_byte = state.stb;
  assign o_srq         = state.srq;

endmodule

// file: pkg/scpi_status_map.svh
// Constants for the status and event reporting block.
// Assumes one 100 MHz clock; values are bit positions, masks and codes.
`ifndef SCPI_STATUS_MAP_SVH
`define SCPI_STATUS_MAP_SVH

// Register group width and used bit positions
`define GROUP_W          16
`define WARN_USED_MASK   16'h00FF
`define OP_USED_MASK     16'h0000

// Status byte bit positions
`define STB_WARN_BIT     3
`define STB_RQS_BIT      6
`define STB_OP_BIT       7
`define STB_W            8

// Reset values
`define MASK_RESET       16'h0000
`define SRE_RESET        8'h00
`define PARAM_RESET      16'h0000

// Test parameter store, index of each entry
`define PARAM_W          16
`define PARAM_IDX_W      4
`define PARAM_COUNT      16
`define P_ACW_VOLT       4'h0
`define P_ACW_CMIN       4'h1
`define P_ACW_CMAX       4'h2
`define P_ACW_RAMP       4'h3
`define P_ACW_DWELL      4'h4
`define P_DCW_VOLT       4'h5
`define P_DCW_CMIN       4'h6
`define P_DCW_CMAX       4'h7
`define P_DCW_RAMP       4'h8
`define P_DCW_DWELL      4'h9
`define P_INS_VOLT       4'hA
`define P_INS_RMIN       4'hB
`define P_INS_RMAX       4'hC
`define P_INS_DWELL      4'hD
`define P_BOND_RMIN      4'hE
`define P_BOND_RMAX      4'hF

// Legal insulation check voltages, in volts
`define INS_V_50         16'h0032
`define INS_V_100        16'h0064
`define INS_V_500        16'h01F4
`define INS_V_1000       16'h03E8

`endif

// file: pkg/scpi_status_pkg.sv
// Types for the status and event reporting block.
// Widths come from scpi_status_map.svh.
`include "scpi_status_map.svh"

package scpi_status_pkg;

  // Commands and queries arriving from the command decoder
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_CLEAR_STATUS,
    CMD_WARN_LIVE_Q,
    CMD_WARN_LATCHED_Q,
    CMD_WARN_MASK_SET,
    CMD_WARN_MASK_Q,
    CMD_OP_LIVE_Q,
    CMD_OP_LATCHED_Q,
    CMD_OP_MASK_SET,
    CMD_OP_MASK_Q,
    CMD_SRE_SET,
    CMD_SRE_Q,
    CMD_STB_Q,
    CMD_PARAM_SET,
    CMD_PARAM_Q
  } cmd_code_t;

  typedef struct packed {
    logic                      valid;
    cmd_code_t                 code;
    logic [`PARAM_IDX_W-1:0]   index;
    logic [`PARAM_W-1:0]       data;
  } cmd_t;

  typedef struct packed {
    logic                      valid;
    logic                      err;
    logic [`PARAM_W-1:0]       data;
  } resp_t;

  typedef struct packed {
    logic [`GROUP_W-1:0]                        warn_sync;
    logic [`GROUP_W-1:0]                        warn_live;
    logic [`GROUP_W-1:0]                        warn_prev;
    logic [`GROUP_W-1:0]                        warn_latched;
    logic [`GROUP_W-1:0]                        warn_mask;
    logic [`GROUP_W-1:0]                        op_latched;
    logic [`GROUP_W-1:0]                        op_mask;
    logic [`STB_W-1:0]                          sre_mask;
    logic [`STB_W-1:0]                          stb;
    logic                                       srq;
    logic [`PARAM_COUNT-1:0][`PARAM_W-1:0]      params;
    resp_t                                      resp;
  } state_t;

endpackage

// file: tb/scpi_status_properties.sv
// Checker for the status and event reporting block.
// Sees only the top module ports; bound at the foot of this file.
`timescale 1ns/1ps
`include "scpi_status_map.svh"
module scpi_status_properties (
  input wire logic                  i_ref_clk,
  input wire logic                  i_reset_n,
  input wire logic [`GROUP_W-1:0]   i_warn_cond,
  input wire scpi_status_pkg::cmd_t i_cmd,
  input wire logic                  o_resp_valid,
  input wire logic                  o_resp_err,
  input wire logic [`PARAM_W-1:0]   o_resp_data,
  input wire logic [`STB_W-1:0]     o_status_byte,
  input wire logic                  o_srq
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // Conditions still long enough to clear the synchroniser
  sequence quiet_s;
    $stable(i_warn_cond)[*6];
  endsequence
  sequence ask_s(c);
    i_cmd.valid && i_cmd.code == c;
  endsequence
  resp_once_a: assert property (i_cmd.valid |=> o_resp_valid)
    else $error("no answer");
  srq_cause_a: assert property (o_srq |-> o_status_byte[3])
    else $error("request without summary");
  op_quiet_a: assert property (!o_status_byte[7])
    else $error("operation summary set");
  unused_zero_a: assert property (ask_s(scpi_status_pkg::CMD_WARN_LIVE_Q)
    |=> o_resp_data[15:8] == 8'h00) else $error("unused bits set");
  op_mask_a: assert property (ask_s(scpi_status_pkg::CMD_OP_MASK_Q)
    |=> o_resp_data == 16'h0000) else $error("operation mask nonzero");
  ins_refuse_a: assert property (ask_s(scpi_status_pkg::CMD_PARAM_SET)
    ##0 (i_cmd.index == `P_INS_VOLT && !(i_cmd.data inside {`INS_V_50,
    `INS_V_100, `INS_V_500, `INS_V_1000})) |=> o_resp_err)
    else $error("bad voltage accepted");
  live_follow_a: assert property (quiet_s ##0
    ask_s(scpi_status_pkg::CMD_WARN_LIVE_Q)
    |=> o_resp_data[7:0] == $past(i_warn_cond[7:0]))
    else $error("live register stale");
  clear_all_a: assert property (quiet_s ##0
    ask_s(scpi_status_pkg::CMD_CLEAR_STATUS) |-> ##2 !o_status_byte[3])
    else $error("summary after clear");
  read_clear_a: assert property (quiet_s ##0
    ask_s(scpi_status_pkg::CMD_WARN_LATCHED_Q) ##[1:2]
    ask_s(scpi_status_pkg::CMD_WARN_LATCHED_Q) |=> o_resp_data == 16'h0000)
    else $error("latched not cleared by read");
endmodule
bind scpi_status_event_reporting scpi_status_properties chk (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_warn_cond(i_warn_cond),
  .i_cmd(i_cmd), .o_resp_valid(o_resp_valid), .o_resp_err(o_resp_err),
  .o_resp_data(o_resp_data), .o_status_byte(o_status_byte), .o_srq(o_srq));

// file: tb/host_model.sv
// Controlling computer: issues one command and collects its answer.
// Assumes the block answers on the same edge that takes a command.
`timescale 1ns/1ps
module host_model (
  input  wire logic            i_ref_clk,
  output scpi_status_pkg::cmd_t o_cmd,
  input  wire logic            i_resp_err,
  input  wire logic [15:0]     i_resp_data
);
  initial o_cmd = '0;
  // Idle fields carry inverted data so stale values are never trusted
  task automatic xfer(input scpi_status_pkg::cmd_code_t c,
    input logic [3:0] ix, input logic [15:0] d,
    output logic e, output logic [15:0] r);
    @(posedge i_ref_clk);
    o_cmd <= '{1'b1, c, ix, d};
    @(posedge i_ref_clk);
    o_cmd <= '{1'b0, c, ~ix, ~d};
    // Answer stands only for the cycle after the taking edge
    #1;
    e = i_resp_err;
    r = i_resp_data;
  endtask
endmodule

// file: tb/scpi_status_event_reporting_tb.sv
// Self-checking bench for the status and event reporting block.
// Assumes the checker is bound and host_model drives commands.
`timescale 1ns/1ps
`include "scpi_status_map.svh"
module scpi_status_event_reporting_tb;
  logic                  i_ref_clk = 1'b0;
  logic                  i_reset_n = 1'b0;
  logic [15:0]           cond = 16'h0000;
  scpi_status_pkg::cmd_t cmd;
  logic                  re, e, srq, rv;
  logic [15:0]           rd, r;
  logic [7:0]            stb;
  int                    n_fail = 0;
  int                    num_checks = 0;
  logic [15:0] ins_v [4] = '{`INS_V_50, `INS_V_100, `INS_V_500, `INS_V_1000};
  // Free-running 100 MHz clock
  always #5 i_ref_clk = ~i_ref_clk;
  scpi_status_event_reporting uut (.i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n), .i_warn_cond(cond), .i_cmd(cmd),
    .o_resp_valid(rv), .o_resp_err(re), .o_resp_data(rd),
    .o_status_byte(stb), .o_srq(srq));
  host_model host (.i_ref_clk(i_ref_clk), .o_cmd(cmd), .i_resp_err(re),
    .i_resp_data(rd));
  task chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    num_checks++;
    if (g !== x) begin
      $display("unexpected %s exp %h got %h", nm, x, g);
      n_fail++;
    end
  endtask
  // Long settle so the sync flop and the live register never hide a change
  task settle(input logic [15:0] v);
    @(posedge i_ref_clk);
    cond <= v;
    repeat (6) @(posedge i_ref_clk);
    #1;
  endtask
  task live_scn;
    settle(16'hFFA5);
    host.xfer(scpi_status_pkg::CMD_WARN_LIVE_Q, 4'h0, 16'h0000, e, r);
    chk("live", 16'h00A5, r);
    chk("resp valid", 16'h0001, {15'h0000, rv});
    host.xfer(scpi_status_pkg::CMD_WARN_LIVE_Q, 4'h0, 16'h0000, e, r);
    chk("live reread", 16'h00A5, r);
  endtask
  task latch_scn;
    settle(16'h0000);
    host.xfer(scpi_status_pkg::CMD_WARN_LATCHED_Q, 4'h0, 16'h0000, e, r);
    chk("latched", 16'h00A5, r);
    host.xfer(scpi_status_pkg::CMD_WARN_LATCHED_Q, 4'h0, 16'h0000, e, r);
    chk("latched reread", 16'h0000, r);
  endtask
  task summary_scn;
    host.xfer(scpi_status_pkg::CMD_WARN_MASK_SET, 4'h0, 16'hFF01, e, r);
    host.xfer(scpi_status_pkg::CMD_SRE_SET, 4'h0, 16'h0008, e, r);
    settle(16'h0001);
    chk("summary", 16'h0148, {7'h00, srq, stb});
    host.xfer(scpi_status_pkg::CMD_WARN_MASK_SET, 4'h0, 16'h0002, e, r);
    settle(16'h0001);
    chk("masked", 16'h0000, {7'h00, srq, stb});
    host.xfer(scpi_status_pkg::CMD_CLEAR_STATUS, 4'h0, 16'h0000, e, r);
    host.xfer(scpi_status_pkg::CMD_WARN_MASK_SET, 4'h0, 16'hFF01, e, r);
    host.xfer(scpi_status_pkg::CMD_WARN_MASK_Q, 4'h0, 16'h0000, e, r);
    chk("mask", 16'h0001, r);
    settle(16'h0001);
    chk("cleared", 16'h0000, {7'h00, srq, stb});
  endtask
  task param_scn;
    for (int i = 0; i < 16; i++) begin
      if (i != 10) begin
        host.xfer(scpi_status_pkg::CMD_PARAM_SET, 4'(i), 16'(4096 + i), e, r);
        host.xfer(scpi_status_pkg::CMD_PARAM_Q, 4'(i), 16'h0000, e, r);
        chk("param", 16'(4096 + i), r);
      end
    end
    for (int i = 0; i < 5; i++) begin
      host.xfer(scpi_status_pkg::CMD_PARAM_SET, `P_INS_VOLT,
        (i < 4) ? ins_v[i] : 16'h0033, e, r);
      chk("ins err", {15'h0000, i == 4}, {15'h0000, e});
      host.xfer(scpi_status_pkg::CMD_PARAM_Q, `P_INS_VOLT, 16'h0000, e, r);
      chk("ins volt", ins_v[(i < 4) ? i : 3], r);
    end
    host.xfer(scpi_status_pkg::CMD_OP_MASK_SET, 4'h0, 16'hFFFF, e, r);
    host.xfer(scpi_status_pkg::CMD_OP_MASK_Q, 4'h0, 16'h0000, e, r);
    chk("op mask", 16'h0000, r);
  endtask
  task results;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence, reset held 16 cycles
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    live_scn();
    latch_scn();
    summary_scn();
    param_scn();
    results();
  end
  // Hang guard counts as a failure
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    n_fail++;
    results();
  end
endmodule
